// ===== mon_boot_ctrl.sv
`timescale 1ns/1ns
module mon_boot_ctrl #(
  parameter int CHANNELS = 6,
  parameter int TICK_CYC = mon_boot_pkg::TICK_CYCLES
) (
  // Clock and power-on reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Analog comparators and pins
  input wire logic EN_COMP,
  input wire logic [1:0] BUS_ADDRESS_SELECT,
  input wire logic EXTERNAL_FAULT_INPUT_N,
  // Flash configuration read port
  output logic [1:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_DATA,
  // Register access from the serial front end
  input wire mon_boot_pkg::reg_req_t REQ,
  output logic REQ_READY,
  output logic [7:0] RDATA,
  output logic RDATA_VALID,
  input wire logic PAGE_SEL_VALID,
  input wire logic [1:0] PAGE_SEL,
  output logic [1:0] PAGE,
  output logic [1:0] BUS_ADDR,
  // Converter
  output mon_boot_pkg::adc_cmd_t ADC_CMD,
  input wire logic ADC_DONE,
  input wire logic [9:0] ADC_DATA,
  // Thresholds and fault routing
  input wire logic [CHANNELS-1:0][7:0] OV_THRESH,
  input wire logic [CHANNELS-1:0][7:0] UV_THRESH,
  input wire logic [CHANNELS-1:0] FAULT_ENABLE,
  input wire logic [CHANNELS-1:0] LOG_ENABLE,
  input wire logic [5:0][CHANNELS:0] GPIO_FAULT_MAP,
  // Outputs
  output logic RESET_OUT,
  output logic [5:0] GPIO_OUT,
  output logic [5:0] GPIO_OE_N,
  output logic FAULT_LOG_REQ,
  output logic WDOG_RUN,
  output logic [CHANNELS:0] FAULTS
);
  import mon_boot_pkg::*;

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  logic [1:0] en_sync_r, ext_sync_r;
  logic [1:0] addr_s1_r, addr_s2_r;
  logic en_prev_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      en_sync_r <= 2'h0;
      ext_sync_r <= 2'h3;
      addr_s1_r <= 2'h0;
      addr_s2_r <= 2'h0;
      en_prev_r <= 1'b0;
    end else begin
      en_sync_r <= {en_sync_r[0], EN_COMP};
      ext_sync_r <= {ext_sync_r[0], EXTERNAL_FAULT_INPUT_N};
      addr_s1_r <= BUS_ADDRESS_SELECT;
      addr_s2_r <= addr_s1_r;
      en_prev_r <= en_sync_r[1];
    end
  end
  wire en_ok = en_sync_r[1];
  wire ext_fault = ~ext_sync_r[1];

  // ------------------------------------------------------------
  // Registers and boot copy
  // ------------------------------------------------------------
  mon_state_t state_r, state_nxt;
  logic [7:0] ctl_r, delay_r, rst_to_r, ocfg_r;
  logic [2:0] boot_idx_r;
  logic addr_taken_r;
  logic [1:0] page_r;
  logic drop_flag_r, latched_r;
  logic [CHANNELS-1:0][9:0] result_r;

  wire booting = (state_r == ST_BOOT);
  wire boot_load = booting && boot_idx_r != 3'h0;
  wire [1:0] load_idx = 2'(boot_idx_r - 3'h1);
  wire wr = REQ.valid && REQ.write && !booting;
  wire wr_ctl = wr && REQ.addr == MONITOR_CONTROL_OFFSET;
  wire wr_dly = wr && REQ.addr == BOOT_DELAY_OFFSET;
  wire wr_rto = wr && REQ.addr == RESET_TIMEOUT_OFFSET;
  wire wr_ocf = wr && REQ.addr == OUTPUT_CONFIG_OFFSET;
  wire wr_sts = wr && REQ.addr == STATUS_OFFSET;
  wire sw_en = ctl_r[CTL_SW_ENABLE_BIT];
  wire margin = ctl_r[CTL_MARGIN_BIT];
  wire [7:0] ctl_wv = booting ? FLASH_DATA : REQ.wdata;

  assign FLASH_ADDR = boot_idx_r[1:0];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ctl_r <= REG_RESET_VALUE;
      delay_r <= REG_RESET_VALUE;
      rst_to_r <= REG_RESET_VALUE;
      ocfg_r <= REG_RESET_VALUE;
      boot_idx_r <= 3'h0;
      page_r <= 2'h0;
    end else begin
      if (booting && boot_idx_r != BOOT_WORDS)
        boot_idx_r <= boot_idx_r + 3'h1;
      if ((boot_load && load_idx == FLASH_IDX_CONTROL) || wr_ctl)
        ctl_r <= ctl_wv;
      if ((boot_load && load_idx == FLASH_IDX_BOOT_DELAY) || wr_dly)
        delay_r <= ctl_wv;
      if ((boot_load && load_idx == FLASH_IDX_RESET_TIMEOUT) || wr_rto)
        rst_to_r <= ctl_wv;
      if ((boot_load && load_idx == FLASH_IDX_OUTPUT_CONFIG) || wr_ocf)
        ocfg_r <= ctl_wv;
      if (PAGE_SEL_VALID && !booting && PAGE_SEL < PAGE_COUNT)
        page_r <= PAGE_SEL;
    end
  end

  // Address select is caught one time, after the synchroniser settles.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      addr_taken_r <= 1'b0;
      BUS_ADDR <= 2'h0;
    end else if (!addr_taken_r && boot_idx_r == BOOT_WORDS) begin
      addr_taken_r <= 1'b1;
      BUS_ADDR <= addr_s2_r;
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  wire [7:0] res_idx = REQ.addr - ADC_RESULT_BASE;
  wire is_res = REQ.addr < 8'(2 * CHANNELS);
  wire [9:0] res_sel = result_r[res_idx[7:1]];
  wire [7:0] res_byte = res_idx[0] ? {res_sel[1:0], 6'h00}
                                   : res_sel[9:2];
  wire [7:0] status_v = 8'(drop_flag_r) << STATUS_EN_DROP_BIT;
  wire [7:0] rd_v =
    is_res ? res_byte :
    REQ.addr == STATUS_OFFSET ? status_v :
    REQ.addr == MONITOR_CONTROL_OFFSET ? ctl_r :
    REQ.addr == BOOT_DELAY_OFFSET ? delay_r :
    REQ.addr == RESET_TIMEOUT_OFFSET ? rst_to_r :
    REQ.addr == OUTPUT_CONFIG_OFFSET ? ocfg_r : 8'h00;

  assign REQ_READY = !booting;
  assign PAGE = page_r;
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
      RDATA_VALID <= 1'b0;
    end else begin
      RDATA_VALID <= REQ.valid && !REQ.write && !booting;
      if (REQ.valid && !REQ.write && !booting)
        RDATA <= rd_v;
    end
  end

  // ------------------------------------------------------------
  // Sequencing state machine and boot-up delay
  // ------------------------------------------------------------
  logic [8:0] tick_cnt_r;
  logic [20:0] dly_cnt_r;
  wire tick = tick_cnt_r == 9'(TICK_CYC - 1);
  wire [20:0] dly_ticks = (21'(5'd16 + 5'(delay_r[3:0])) << delay_r[7:4])
                        + 21'(BOOT_FIXED_TICKS);
  wire go = en_ok && sw_en && !latched_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_BOOT: begin
        if (boot_idx_r == BOOT_WORDS)
          state_nxt = ST_IDLE;
      end
      ST_IDLE: begin
        if (go)
          state_nxt = ST_DELAY;
      end
      ST_DELAY: begin
        if (!go)
          state_nxt = ST_IDLE;
        else if (tick && dly_cnt_r >= dly_ticks)
          state_nxt = ST_MONITOR;
      end
      default: begin
        if (!go)
          state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_r <= ST_BOOT;
      tick_cnt_r <= 9'h000;
      dly_cnt_r <= 21'h000000;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick ? 9'h000 : tick_cnt_r + 9'h001;
      if (state_r != ST_DELAY)
        dly_cnt_r <= 21'h000000;
      else if (tick)
        dly_cnt_r <= dly_cnt_r + 21'h000001;
    end
  end
  wire monitoring = (state_r == ST_MONITOR);

  // Enable-drop flag: falling edges only, and a set beats a clear.
  wire en_fall = en_prev_r && !en_ok;
  wire sw_fall = wr_ctl && sw_en && !REQ.wdata[CTL_SW_ENABLE_BIT];
  wire drop_set = monitoring && (en_fall || sw_fall);
  wire drop_clr = wr_sts && REQ.wdata[STATUS_EN_DROP_BIT];

  // ------------------------------------------------------------
  // Channel scan and compare
  // ------------------------------------------------------------
  logic [2:0] ch_r;
  logic pend_r, cyc_done_r;
  logic [CHANNELS-1:0] ov_r, uv_r;
  logic [CHANNELS:0] fault_r;
  logic log_lock_r;
  wire last_ch = ch_r == 3'(CHANNELS - 1);

  assign ADC_CMD.start = monitoring && !pend_r;
  assign ADC_CMD.channel = ch_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ch_r <= 3'h0;
      pend_r <= 1'b0;
      cyc_done_r <= 1'b0;
      result_r <= '0;
    end else begin
      cyc_done_r <= 1'b0;
      if (!monitoring) begin
        ch_r <= 3'h0;
        pend_r <= 1'b0;
      end else if (!pend_r) begin
        pend_r <= 1'b1;
      end else if (ADC_DONE) begin
        pend_r <= 1'b0;
        result_r[ch_r] <= ADC_DATA;
        ch_r <= last_ch ? 3'h0 : ch_r + 3'h1;
        cyc_done_r <= last_ch;
      end
    end
  end

  // Only the eight upper bits of a result meet the thresholds.
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_cmp
      always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
          ov_r[g] <= 1'b0;
          uv_r[g] <= 1'b0;
        end else if (!monitoring) begin
          ov_r[g] <= 1'b0;
          uv_r[g] <= 1'b0;
        end else if (cyc_done_r) begin
          ov_r[g] <= result_r[g][9:2] > OV_THRESH[g];
          uv_r[g] <= result_r[g][9:2] < UV_THRESH[g];
        end
      end
    end
  endgenerate

  wire [CHANNELS-1:0] chan_evt = (ov_r | uv_r) & FAULT_ENABLE;
  wire [CHANNELS:0] rec_evt = {ext_fault && !booting,
                               margin ? {CHANNELS{1'b0}} : chan_evt};
  wire log_evt = |(chan_evt & LOG_ENABLE) && !margin;
  wire latch_mode = ocfg_r[OCFG_LATCH_MODE_BIT];

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      fault_r <= '0;
      log_lock_r <= 1'b0;
      FAULT_LOG_REQ <= 1'b0;
      drop_flag_r <= 1'b0;
      latched_r <= 1'b0;
    end else begin
      fault_r <= rec_evt;
      FAULT_LOG_REQ <= log_evt && !log_lock_r;
      if (log_evt)
        log_lock_r <= 1'b1;
      if (drop_set)
        drop_flag_r <= 1'b1;
      else if (drop_clr)
        drop_flag_r <= 1'b0;
      if (en_fall || sw_fall || (!en_ok && !sw_en))
        latched_r <= 1'b0;
      else if (latch_mode && monitoring && |chan_evt)
        latched_r <= 1'b1;
    end
  end
  assign FAULTS = fault_r;

  // ------------------------------------------------------------
  // Reset output, general pins and watchdog
  // ------------------------------------------------------------
  logic [16:0] rst_cnt_r;
  logic rst_hold_r;
  wire all_good = monitoring && !(|(ov_r | uv_r));
  wire [16:0] rst_ticks = {rst_to_r, 9'h000};
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rst_cnt_r <= 17'h00000;
      rst_hold_r <= 1'b1;
    end else if (!all_good) begin
      rst_cnt_r <= 17'h00000;
      rst_hold_r <= 1'b1;
    end else if (tick) begin
      if (rst_cnt_r >= rst_ticks)
        rst_hold_r <= 1'b0;
      else
        rst_cnt_r <= rst_cnt_r + 17'h00001;
    end
  end

  wire rst_pol_high = ocfg_r[OCFG_RESET_POL_BIT];
  assign RESET_OUT = booting ? 1'b0 :
                     (rst_pol_high ? rst_hold_r : !rst_hold_r);

  // Pins are open-drain fault outputs: enable low pulls the pin low.
  generate
    for (g = 0; g < 6; g++) begin : g_gpio
      assign GPIO_OUT[g] = 1'b0;
      assign GPIO_OE_N[g] = booting || !en_ok ||
                            !(|(fault_r & GPIO_FAULT_MAP[g]));
    end
  endgenerate

  assign WDOG_RUN = ctl_r[CTL_WDOG_INDEP_BIT] ? !booting
                                              : monitoring;

endmodule

// ===== mon_boot_pkg.sv
package mon_boot_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADC_RESULT_BASE = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h20;
  localparam logic [7:0] MONITOR_CONTROL_OFFSET = 8'h73;
  localparam logic [7:0] BOOT_DELAY_OFFSET = 8'h77;
  localparam logic [7:0] RESET_TIMEOUT_OFFSET = 8'h78;
  localparam logic [7:0] OUTPUT_CONFIG_OFFSET = 8'h79;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // Field positions.
  localparam int CTL_SW_ENABLE_BIT = 0;
  localparam int CTL_MARGIN_BIT = 2;
  localparam int CTL_WDOG_INDEP_BIT = 4;
  localparam int STATUS_EN_DROP_BIT = 2;
  localparam int OCFG_RESET_POL_BIT = 0;
  localparam int OCFG_LATCH_MODE_BIT = 1;

  // Flash image order copied during boot.
  localparam logic [1:0] FLASH_IDX_CONTROL = 2'h0;
  localparam logic [1:0] FLASH_IDX_BOOT_DELAY = 2'h1;
  localparam logic [1:0] FLASH_IDX_RESET_TIMEOUT = 2'h2;
  localparam logic [1:0] FLASH_IDX_OUTPUT_CONFIG = 2'h3;
  localparam logic [2:0] BOOT_WORDS = 3'h4;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_NS = 5000;
  localparam int TICK_CYCLES = TICK_NS / CLOCK_PERIOD_NS;
  localparam int BOOT_FIXED_US = 480;
  localparam int BOOT_FIXED_TICKS = BOOT_FIXED_US * 1000 / TICK_NS;
  localparam int BOOT_MAX_US = 150;
  localparam int BOOT_MAX_CYCLES = BOOT_MAX_US * 1000 / CLOCK_PERIOD_NS;
  localparam int CONV_MAX_US = 5;
  localparam int CONV_MAX_CYCLES = CONV_MAX_US * 1000 / CLOCK_PERIOD_NS;

  localparam logic [1:0] PAGE_COUNT = 2'h3;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_IDLE = 2'b01,
    ST_DELAY = 2'b11,
    ST_MONITOR = 2'b10
  } mon_state_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic start;
    logic [2:0] channel;
  } adc_cmd_t;

endpackage

// ===== mon_boot_monitor.sv
`timescale 1ns/1ns
module mon_boot_monitor #(
  parameter int CHANNELS = 6
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Stimulus seen
  input wire logic EN_COMP,
  input wire mon_boot_pkg::reg_req_t REQ,
  input wire logic PAGE_SEL_VALID,
  input wire logic [1:0] PAGE_SEL,
  // Outputs judged
  input wire logic REQ_READY,
  input wire logic RDATA_VALID,
  input wire logic [1:0] PAGE,
  input wire logic [1:0] BUS_ADDR,
  input wire mon_boot_pkg::adc_cmd_t ADC_CMD,
  input wire logic RESET_OUT,
  input wire logic [5:0] GPIO_OE_N,
  input wire logic [CHANNELS:0] FAULTS
);
  import mon_boot_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  a_boot_not_ready: assert property (
    $rose(RST_N) |-> !REQ_READY [*4])
    else $error("register port ready too early");
  a_boot_silent: assert property (
    REQ.valid && !REQ_READY |=> !RDATA_VALID)
    else $error("answer to a refused request");
  a_read_answered: assert property (
    REQ.valid && !REQ.write && REQ_READY |=> RDATA_VALID)
    else $error("accepted read not answered");
  a_boot_reset_low: assert property (
    !REQ_READY |-> !RESET_OUT)
    else $error("reset output high during boot");
  a_boot_pins_hiz: assert property (
    !REQ_READY |-> GPIO_OE_N == 6'h3f)
    else $error("pin driven during boot");
  a_boot_masked: assert property (
    !REQ_READY |-> FAULTS == '0 && !ADC_CMD.start)
    else $error("fault or conversion during boot");
  a_en_low_quiet: assert property (
    !EN_COMP [*6] |-> GPIO_OE_N == 6'h3f)
    else $error("pin driven with enable low");
  a_page_taken: assert property (
    PAGE_SEL_VALID && REQ_READY && PAGE_SEL != 2'h3
      |=> PAGE == $past(PAGE_SEL))
    else $error("page select not taken");
  a_page_refused: assert property (
    PAGE_SEL_VALID && PAGE_SEL == 2'h3 |=> $stable(PAGE))
    else $error("invalid page taken");
  a_address_held: assert property (
    REQ_READY && $past(REQ_READY) |-> $stable(BUS_ADDR))
    else $error("bus address changed after boot");
endmodule

bind mon_boot_ctrl mon_boot_monitor #(.CHANNELS(CHANNELS))
  mon_boot_monitor_inst (.CLOCK(CLOCK), .RST_N(RST_N), .EN_COMP(EN_COMP),
  .REQ(REQ), .PAGE_SEL_VALID(PAGE_SEL_VALID), .PAGE_SEL(PAGE_SEL),
  .REQ_READY(REQ_READY), .RDATA_VALID(RDATA_VALID), .PAGE(PAGE),
  .BUS_ADDR(BUS_ADDR), .ADC_CMD(ADC_CMD), .RESET_OUT(RESET_OUT),
  .GPIO_OE_N(GPIO_OE_N), .FAULTS(FAULTS));

// ===== mon_boot_partner.sv
`timescale 1ns/1ns
module mon_boot_partner (
  // Clock
  input wire logic CLOCK,
  // Flash read port
  input wire logic [1:0] FLASH_ADDR,
  output logic [7:0] FLASH_DATA = 8'h00,
  // Converter
  input wire mon_boot_pkg::adc_cmd_t ADC_CMD,
  output logic ADC_DONE = 1'b0,
  output logic [9:0] ADC_DATA = 10'h000
);
  import mon_boot_pkg::*;
  localparam logic [9:0] SAMPLE = 10'h155;
  logic [7:0] image [4] = '{8'h01, 8'h00, 8'h03, 8'h01};
  logic [1:0] wait_r = 2'h0;
  logic busy_r = 1'b0;
  // The start strobe lasts one cycle, so the model remembers it and answers
  // three cycles later. Between results the data lines show the inverse
  // sample, so a stale value is never mistaken for a fresh conversion.
  always @(posedge CLOCK) begin
    FLASH_DATA <= image[FLASH_ADDR];
    if (ADC_CMD.start) begin
      busy_r <= 1'b1;
      wait_r <= 2'h0;
      ADC_DONE <= 1'b0;
      ADC_DATA <= ~SAMPLE;
    end else if (busy_r && wait_r == 2'h2) begin
      busy_r <= 1'b0;
      ADC_DONE <= 1'b1;
      ADC_DATA <= SAMPLE;
    end else begin
      wait_r <= busy_r ? wait_r + 2'h1 : 2'h0;
      ADC_DONE <= 1'b0;
      ADC_DATA <= ~SAMPLE;
    end
  end
endmodule

// ===== test_mon_boot_ctrl.sv
`timescale 1ns/1ns
module test_mon_boot_ctrl;
  import mon_boot_pkg::*;
  // --------------------
  // Bench signals
  // --------------------
  localparam int TICK = 4;
  localparam int DELAY_CYC = (16 + 96) * TICK;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic EN_COMP = 1'b0;
  logic EXTERNAL_FAULT_INPUT_N = 1'b1;
  logic PAGE_SEL_VALID = 1'b0;
  logic [1:0] BUS_ADDRESS_SELECT = 2'h2;
  logic [1:0] PAGE_SEL = 2'h0;
  reg_req_t REQ = '0;
  logic [5:0][7:0] OV_THRESH = '1;
  logic [5:0][7:0] UV_THRESH = '0;
  logic [5:0] FAULT_ENABLE = 6'h01;
  logic [5:0] LOG_ENABLE = 6'h00;
  logic [5:0][6:0] GPIO_FAULT_MAP = {6{7'h01}};
  logic [1:0] FLASH_ADDR, PAGE, BUS_ADDR;
  logic [7:0] FLASH_DATA, RDATA;
  logic [9:0] ADC_DATA;
  logic [5:0] GPIO_OUT, GPIO_OE_N;
  logic [6:0] FAULTS;
  logic REQ_READY, RDATA_VALID, ADC_DONE, RESET_OUT, FAULT_LOG_REQ;
  logic WDOG_RUN;
  adc_cmd_t ADC_CMD;
  int errors = 0;
  int checks_done = 0;

  mon_boot_ctrl #(.CHANNELS(6), .TICK_CYC(TICK)) mon_boot_ctrl_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .EN_COMP(EN_COMP),
    .BUS_ADDRESS_SELECT(BUS_ADDRESS_SELECT),
    .EXTERNAL_FAULT_INPUT_N(EXTERNAL_FAULT_INPUT_N),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .REQ(REQ),
    .REQ_READY(REQ_READY), .RDATA(RDATA), .RDATA_VALID(RDATA_VALID),
    .PAGE_SEL_VALID(PAGE_SEL_VALID), .PAGE_SEL(PAGE_SEL), .PAGE(PAGE),
    .BUS_ADDR(BUS_ADDR), .ADC_CMD(ADC_CMD), .ADC_DONE(ADC_DONE),
    .ADC_DATA(ADC_DATA), .OV_THRESH(OV_THRESH), .UV_THRESH(UV_THRESH),
    .FAULT_ENABLE(FAULT_ENABLE), .LOG_ENABLE(LOG_ENABLE),
    .GPIO_FAULT_MAP(GPIO_FAULT_MAP), .RESET_OUT(RESET_OUT),
    .GPIO_OUT(GPIO_OUT), .GPIO_OE_N(GPIO_OE_N),
    .FAULT_LOG_REQ(FAULT_LOG_REQ), .WDOG_RUN(WDOG_RUN), .FAULTS(FAULTS));

  mon_boot_partner mon_boot_partner_inst (.CLOCK(CLOCK),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .ADC_CMD(ADC_CMD),
    .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA));

  initial forever #5 CLOCK = ~CLOCK;

  // --------------------
  // Shared tasks
  // --------------------
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Only the one register port is ever used by this host.
  task automatic reg_acc(input logic wr, input logic [7:0] a, d,
                         output logic [7:0] q);
    REQ = {1'b1, wr, a, d};
    @(negedge CLOCK);
    REQ = '0;
    q = (RDATA_VALID === 1'b1) ? RDATA : 8'hxx;
    @(negedge CLOCK);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_boot();
    int n;
    logic bad;
    logic [7:0] q;
    bad = 1'b0;
    repeat (16) @(negedge CLOCK);
    RST_N = 1'b1;
    REQ = {1'b1, 1'b0, MONITOR_CONTROL_OFFSET, 8'h00};
    for (n = 0; n < BOOT_MAX_CYCLES && REQ_READY !== 1'b1; n++) begin
      if (RESET_OUT !== 1'b0 || GPIO_OE_N !== 6'h3f) bad = 1'b1;
      if (RDATA_VALID !== 1'b0) bad = 1'b1;
      @(negedge CLOCK);
    end
    chk(bad, 1'b0);
    chk(n < BOOT_MAX_CYCLES, 1'b1);
    if (n >= BOOT_MAX_CYCLES) test_done();
    @(negedge CLOCK);
    REQ = '0;
    chk(RDATA_VALID, 1'b1);
    chk(RDATA, 8'h01);
    @(negedge CLOCK);
    reg_acc(1'b0, RESET_TIMEOUT_OFFSET, 8'h00, q);
    chk(q, 8'h03);
    $display("boot test done");
  endtask

  task automatic t_regs();
    logic [7:0] q;
    reg_acc(1'b0, STATUS_OFFSET, 8'h00, q);
    chk(q, 8'h00);
    reg_acc(1'b0, 8'hf0, 8'h00, q);
    chk(q, 8'h00);
    reg_acc(1'b1, MONITOR_CONTROL_OFFSET, 8'h15, q);
    reg_acc(1'b0, MONITOR_CONTROL_OFFSET, 8'h00, q);
    chk(q, 8'h15);
    chk(WDOG_RUN, 1'b1);
    reg_acc(1'b1, MONITOR_CONTROL_OFFSET, 8'h01, q);
    chk(WDOG_RUN, 1'b0);
    BUS_ADDRESS_SELECT = 2'h1;
    repeat (4) @(negedge CLOCK);
    chk(BUS_ADDR, 2'h2);
    $display("register test done");
  endtask

  task automatic t_page();
    logic [1:0] sel [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
    logic [1:0] exp [4] = '{2'h2, 2'h2, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      PAGE_SEL = sel[i];
      PAGE_SEL_VALID = 1'b1;
      @(negedge CLOCK);
      PAGE_SEL_VALID = 1'b0;
      chk(PAGE, exp[i]);
      @(negedge CLOCK);
    end
    $display("page test done");
  endtask

  // The start window allows for the synchroniser and tick alignment.
  task automatic t_monitor();
    int n;
    logic [7:0] q;
    EN_COMP = 1'b1;
    for (n = 0; n < 1000 && ADC_CMD.start !== 1'b1; n++) @(negedge CLOCK);
    chk(n >= DELAY_CYC && n <= DELAY_CYC + 3 * TICK, 1'b1);
    if (n >= 1000) test_done();
    repeat (CONV_MAX_CYCLES) @(negedge CLOCK);
    reg_acc(1'b0, ADC_RESULT_BASE, 8'h00, q);
    chk(q, 8'h55);
    reg_acc(1'b0, ADC_RESULT_BASE + 8'h01, 8'h00, q);
    chk(q, 8'h40);
    chk(FAULTS[0], 1'b0);
    UV_THRESH[0] = 8'h60;
    repeat (CONV_MAX_CYCLES) @(negedge CLOCK);
    chk(FAULTS[0], 1'b1);
    chk(GPIO_OE_N, 6'h00);
    UV_THRESH[0] = 8'h00;
    EN_COMP = 1'b0;
    repeat (8) @(negedge CLOCK);
    chk(GPIO_OE_N, 6'h3f);
    reg_acc(1'b0, STATUS_OFFSET, 8'h00, q);
    chk(q, 8'h04);
    repeat (8) @(negedge CLOCK);
    reg_acc(1'b0, STATUS_OFFSET, 8'h00, q);
    chk(q, 8'h04);
    reg_acc(1'b1, STATUS_OFFSET, 8'h04, q);
    reg_acc(1'b0, STATUS_OFFSET, 8'h00, q);
    chk(q, 8'h00);
    $display("monitor test done");
  endtask

  initial begin
    t_boot();
    t_regs();
    t_page();
    t_monitor();
    test_done();
  end
endmodule
